// ===== core/motion_cfg.svh
// constants for the motion sensor report command unit
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

// clock and sample rates in hertz
`define MS_CLK_HZ 32'h01312D00
`define MS_JOY_RATE_HZ 32'h00000341
`define MS_HS_RATE_HZ 32'h00001A08

// command codes in byte zero of an output report, high speed toggle arguments in byte one
`define MS_CMD_SET_PARAMS 8'h00
`define MS_CMD_STORE 8'h01
`define MS_CMD_HIGH_SPEED 8'h04
`define MS_HS_ON 8'h01
`define MS_HS_OFF 8'h00

// parameter word: byte fields as carried in report bytes one to four
`define MS_ACC_RANGE_LSB 0
`define MS_ACC_FILT_LSB 8
`define MS_GYR_RANGE_LSB 16
`define MS_GYR_FILT_LSB 24
`define MS_PARAM_RESET 32'h00000000

// filter flag bit positions
`define MS_AF_SEC_BIT 7
`define MS_AF_HP_BIT 6
`define MS_AF_BWSEL_BIT 5
`define MS_GF_HP_BIT 7

// decoded ranges
`define MS_ACC_2G 5'h02
`define MS_ACC_4G 5'h04
`define MS_ACC_8G 5'h08
`define MS_ACC_16G 5'h10
`define MS_GYR_125 11'h07D
`define MS_GYR_245 11'h0F5
`define MS_GYR_500 11'h1F4
`define MS_GYR_1000 11'h3E8
`define MS_GYR_2000 11'h7D0

// accelerometer cutoffs in units of 0.01 Hz (normal / high speed)
`define MS_CUT_W 19
`define MS_PRI_WIDE_N 19'h0A2B2
`define MS_PRI_WIDE_H 19'h514C8
`define MS_PRI_NARROW_N 19'h05159
`define MS_PRI_NARROW_H 19'h28A64
`define MS_BW0_N 19'h00682
`define MS_BW0_H 19'h03408
`define MS_BW1_N 19'h00341
`define MS_BW1_H 19'h01A04
`define MS_BW2_N 19'h02428
`define MS_BW2_H 19'h12110
`define MS_BW3_N 19'h000D0
`define MS_BW3_H 19'h00681

// gyroscope low pass in Hz, high pass in mHz
`define MS_GLP_N 9'h0F5
`define MS_GLP_H 9'h15F
`define MS_GHP_BW0 11'h010
`define MS_GHP_BW1 11'h041
`define MS_GHP_BW2 11'h104
`define MS_GHP_BW3 11'h410

`endif

// ===== core/motion_pkg.sv
// types shared by the motion sensor report command unit
package motion_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,
        MODE_HIGH_SPEED = 2'b10
    } speed_mode_t;

    typedef enum logic [2:0] {
        CHAIN_PRI = 3'b001,
        CHAIN_PRI_HIPASS = 3'b010,
        CHAIN_PRI_SEC = 3'b100
    } accel_chain_t;
endpackage

// ===== core/rate_tick.sv
// fractional rate divider: one pulse per period of a rate in hertz
`timescale 1ns/100ps
`include "motion_cfg.svh"
module rate_tick #(
    parameter int CLK_HZ = `MS_CLK_HZ,
    parameter int RATE_HZ = `MS_JOY_RATE_HZ
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_run,
    // pulse out
    output logic o_tick
);
    localparam logic [31:0] STEP = 32'(RATE_HZ);
    localparam logic [31:0] LIMIT = 32'(CLK_HZ);

    logic [31:0] acc_q;
    logic [31:0] sum;

    assign sum = acc_q + STEP;

    // phase accumulator keeps the long-term rate exact despite a fractional period
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            acc_q <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (sum >= LIMIT) begin
            acc_q <= sum - LIMIT;
            o_tick <= 1'b1;
        end else begin
            acc_q <= sum;
            o_tick <= 1'b0;
        end
    end
endmodule

// ===== core/motion_hid_unit.sv
// motion sensor report command unit: decodes host reports, paces joystick and stream reports
`timescale 1ns/100ps
`include "motion_cfg.svh"

module motion_hid_unit
    import motion_pkg::*;
#(
    parameter int CLK_HZ = `MS_CLK_HZ,
    parameter int JOY_RATE_HZ = `MS_JOY_RATE_HZ,
    parameter int HS_RATE_HZ = `MS_HS_RATE_HZ,
    parameter int SETS = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // host output report, byte zero in bits 7:0
    input wire logic i_rpt_valid,
    input wire logic [63:0] i_rpt_data,
    // bus attach event and stored parameter image
    input wire logic i_attach,
    input wire logic [31:0] i_nv_params,
    // sensor samples and buttons
    input wire logic [15:0] i_accel_x,
    input wire logic [15:0] i_accel_y,
    input wire logic [15:0] i_accel_z,
    input wire logic [15:0] i_gyro_x,
    input wire logic [15:0] i_gyro_y,
    input wire logic [15:0] i_gyro_z,
    input wire logic [15:0] i_temp,
    input wire logic [7:0] i_button_n,
    // command results
    output logic o_cmd_rejected,
    output logic o_nv_write,
    output logic [31:0] o_nv_params,
    output logic o_high_speed,
    output logic [31:0] o_params,
    // decoded sensor configuration
    output logic [4:0] o_accel_range_g,
    output logic [2:0] o_accel_chain,
    output logic o_accel_low_latency,
    output logic [`MS_CUT_W-1:0] o_accel_pri_cutoff,
    output logic [`MS_CUT_W-1:0] o_accel_stage2_cutoff,
    output logic [10:0] o_gyro_range_dps,
    output logic [8:0] o_gyro_lp_cutoff,
    output logic o_gyro_hp_on,
    output logic [10:0] o_gyro_hp_cutoff,
    // joystick report
    output logic o_joy_valid,
    output logic [103:0] o_joy_report,
    // stream reports, endpoint 3 and endpoint 4
    output logic o_ep3_valid,
    output logic [SETS*48+15:0] o_ep3_report,
    output logic o_ep4_valid,
    output logic [SETS*48+15:0] o_ep4_report
);
    localparam int JOY_GAP_MIN = CLK_HZ / JOY_RATE_HZ;
    localparam int JOY_GAP_MAX = JOY_GAP_MIN + 1;
    localparam logic [3:0] LAST_SET = 4'(SETS - 1);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    // two stages so the release never lands near a clock edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    speed_mode_t mode_q;
    speed_mode_t mode_d;
    logic [31:0] params_q;
    logic [7:0] cmd_code;
    logic [7:0] cmd_arg;
    logic [7:0] new_aflg;
    logic [7:0] new_grange;
    logic range_ok;
    logic set_ok;
    logic store_ok;
    logic hs_ok;

    assign cmd_code = i_rpt_data[7:0];
    assign cmd_arg = i_rpt_data[15:8];
    assign new_aflg = i_rpt_data[23:16];
    assign new_grange = i_rpt_data[31:24];
    // reserved gyro codes and out-of-range accel codes in a set report are never applied; attach loads stored ones unchecked
    assign range_ok = (i_rpt_data[15:10] == 6'h00) && (new_grange <= 8'h06)
        && (new_grange != 8'h03) && (new_grange != 8'h05);
    assign set_ok = i_rpt_valid && (cmd_code == `MS_CMD_SET_PARAMS) && range_ok
        && (mode_q == MODE_NORMAL)
        && !(new_aflg[`MS_AF_HP_BIT] && new_aflg[`MS_AF_BWSEL_BIT]);
    assign store_ok = i_rpt_valid && (cmd_code == `MS_CMD_STORE)
        && (i_rpt_data[63:8] == 56'h00000000000000);
    assign hs_ok = i_rpt_valid && (cmd_code == `MS_CMD_HIGH_SPEED)
        && ((cmd_arg == `MS_HS_ON) || (cmd_arg == `MS_HS_OFF))
        && (i_rpt_data[63:16] == 48'h000000000000);

    // mode follows an accepted toggle; attach restarts in joystick mode
    always_comb begin
        mode_d = mode_q;
        if (i_attach) begin
            mode_d = MODE_NORMAL;
        end else if (hs_ok) begin
            mode_d = (cmd_arg == `MS_HS_ON) ? MODE_HIGH_SPEED : MODE_NORMAL;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_NORMAL;
            o_high_speed <= 1'b0;
        end else begin
            mode_q <= mode_d;
            o_high_speed <= (mode_d == MODE_HIGH_SPEED);
        end
    end

    // active parameters: volatile until stored, reloaded on attach
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            params_q <= `MS_PARAM_RESET;
        end else if (i_attach) begin
            params_q <= i_nv_params;
        end else if (set_ok) begin
            params_q <= i_rpt_data[39:8];
        end
    end

    // storage write strobe carries the active set; unknown codes only flag
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_nv_write <= 1'b0;
            o_nv_params <= `MS_PARAM_RESET;
            o_cmd_rejected <= 1'b0;
            o_params <= `MS_PARAM_RESET;
        end else begin
            o_nv_write <= store_ok && !i_attach;
            if (store_ok) begin
                o_nv_params <= params_q;
            end
            o_cmd_rejected <= i_rpt_valid && !(set_ok || store_ok || hs_ok);
            o_params <= params_q;
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic [7:0] aflg;
    logic [7:0] gflg;
    logic hs_now;

    assign aflg = params_q[`MS_ACC_FILT_LSB +: 8];
    assign gflg = params_q[`MS_GYR_FILT_LSB +: 8];
    assign hs_now = (mode_q == MODE_HIGH_SPEED);

    // ranges; the sample words stay 16 bits whatever is picked
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_accel_range_g <= `MS_ACC_2G;
            o_gyro_range_dps <= `MS_GYR_245;
        end else begin
            case (params_q[`MS_ACC_RANGE_LSB +: 2])
                2'h0: o_accel_range_g <= `MS_ACC_2G;
                2'h1: o_accel_range_g <= `MS_ACC_16G;
                2'h2: o_accel_range_g <= `MS_ACC_4G;
                default: o_accel_range_g <= `MS_ACC_8G;
            endcase
            case (params_q[`MS_GYR_RANGE_LSB +: 3])
                3'h1: o_gyro_range_dps <= `MS_GYR_125;
                3'h2: o_gyro_range_dps <= `MS_GYR_500;
                3'h4: o_gyro_range_dps <= `MS_GYR_1000;
                3'h6: o_gyro_range_dps <= `MS_GYR_2000;
                default: o_gyro_range_dps <= `MS_GYR_245;
            endcase
        end
    end

    // accelerometer chain and cutoffs, scaled by the current speed mode
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_accel_chain <= CHAIN_PRI;
            o_accel_low_latency <= 1'b0;
            o_accel_pri_cutoff <= `MS_PRI_WIDE_N;
            o_accel_stage2_cutoff <= `MS_BW0_N;
        end else begin
            if (aflg[`MS_AF_HP_BIT]) begin
                o_accel_chain <= CHAIN_PRI_HIPASS;
            end else if (aflg[`MS_AF_SEC_BIT]) begin
                o_accel_chain <= CHAIN_PRI_SEC;
            end else begin
                o_accel_chain <= CHAIN_PRI;
            end
            o_accel_low_latency <= aflg[`MS_AF_SEC_BIT] && !aflg[`MS_AF_HP_BIT]
                && aflg[`MS_AF_BWSEL_BIT];
            // bit 5 narrows the primary low pass only when no second stage follows it
            if (aflg[`MS_AF_BWSEL_BIT] && !aflg[`MS_AF_SEC_BIT] && !aflg[`MS_AF_HP_BIT]) begin
                o_accel_pri_cutoff <= hs_now ? `MS_PRI_NARROW_H : `MS_PRI_NARROW_N;
            end else begin
                o_accel_pri_cutoff <= hs_now ? `MS_PRI_WIDE_H : `MS_PRI_WIDE_N;
            end
            case (aflg[1:0])
                2'h0: begin
                    if (aflg[`MS_AF_HP_BIT]) begin
                        o_accel_stage2_cutoff <= hs_now ? `MS_PRI_NARROW_H : `MS_PRI_NARROW_N;
                    end else begin
                        o_accel_stage2_cutoff <= hs_now ? `MS_BW0_H : `MS_BW0_N;
                    end
                end
                2'h1: o_accel_stage2_cutoff <= hs_now ? `MS_BW1_H : `MS_BW1_N;
                2'h2: o_accel_stage2_cutoff <= hs_now ? `MS_BW2_H : `MS_BW2_N;
                default: o_accel_stage2_cutoff <= hs_now ? `MS_BW3_H : `MS_BW3_N;
            endcase
        end
    end

    // gyro filters: low pass always on, high pass cutoff ignores speed mode
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_gyro_lp_cutoff <= `MS_GLP_N;
            o_gyro_hp_on <= 1'b0;
            o_gyro_hp_cutoff <= `MS_GHP_BW0;
        end else begin
            o_gyro_lp_cutoff <= hs_now ? `MS_GLP_H : `MS_GLP_N;
            o_gyro_hp_on <= gflg[`MS_GF_HP_BIT];
            case (gflg[1:0])
                2'h0: o_gyro_hp_cutoff <= `MS_GHP_BW0;
                2'h1: o_gyro_hp_cutoff <= `MS_GHP_BW1;
                2'h2: o_gyro_hp_cutoff <= `MS_GHP_BW2;
                default: o_gyro_hp_cutoff <= `MS_GHP_BW3;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sample pacing and joystick report
    // ------------------------------------------------------------
    logic joy_tick;
    logic hs_tick;

    rate_tick #(.CLK_HZ(CLK_HZ), .RATE_HZ(JOY_RATE_HZ)) u_joy_tick (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_run(mode_q == MODE_NORMAL),
        .o_tick(joy_tick)
    );

    rate_tick #(.CLK_HZ(CLK_HZ), .RATE_HZ(HS_RATE_HZ)) u_hs_tick (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_run(hs_now),
        .o_tick(hs_tick)
    );

    // one report per tick; buttons inverted so a pressed contact reads one
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_joy_valid <= 1'b0;
            o_joy_report <= 104'h0;
        end else begin
            o_joy_valid <= joy_tick;
            if (joy_tick) begin
                o_joy_report <= {~i_button_n, i_gyro_z, i_gyro_y, i_gyro_x,
                    i_accel_z, i_accel_y, i_accel_x};
            end
        end
    end

    // ------------------------------------------------------------
    // high speed set collection
    // ------------------------------------------------------------
    logic [47:0] acc_mem [0:SETS-1];
    logic [47:0] gyr_mem [0:SETS-1];
    logic [SETS*48-1:0] acc_pack;
    logic [SETS*48-1:0] gyr_pack;
    logic [3:0] set_cnt_q;
    logic pack_q;
    logic [15:0] temp_hold_q;

    // sets stored with X in the low word, so each axis goes out LSB first
    always_ff @(posedge i_clk) begin
        if (hs_tick) begin
            acc_mem[set_cnt_q] <= {i_accel_z, i_accel_y, i_accel_x};
            gyr_mem[set_cnt_q] <= {i_gyro_z, i_gyro_y, i_gyro_x};
        end
    end

    // a partial group is dropped when the mode ends, never sent short
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            set_cnt_q <= 4'h0;
            pack_q <= 1'b0;
            temp_hold_q <= 16'h0000;
        end else begin
            pack_q <= hs_tick && (set_cnt_q == LAST_SET);
            if (hs_tick) begin
                set_cnt_q <= (set_cnt_q == LAST_SET) ? 4'h0 : set_cnt_q + 4'h1;
                if (set_cnt_q == LAST_SET) begin
                    temp_hold_q <= i_temp;
                end
            end else if (!hs_now) begin
                set_cnt_q <= 4'h0;
            end
        end
    end

    // flatten the stored sets in arrival order
    for (genvar k = 0; k < SETS; k++) begin : g_pack
        assign acc_pack[48*k +: 48] = acc_mem[k];
        assign gyr_pack[48*k +: 48] = gyr_mem[k];
    end

    // both endpoints launch together; temperature MSB lands in the top byte
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ep3_valid <= 1'b0;
            o_ep4_valid <= 1'b0;
            o_ep3_report <= '0;
            o_ep4_report <= '0;
        end else begin
            o_ep3_valid <= pack_q;
            o_ep4_valid <= pack_q;
            if (pack_q) begin
                o_ep3_report <= {temp_hold_q, acc_pack};
                o_ep4_report <= {temp_hold_q, gyr_pack};
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] gap_q;
    logic joy_seen_q;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 16'h0000;
            joy_seen_q <= 1'b0;
        end else begin
            gap_q <= o_joy_valid ? 16'h0001 : gap_q + 16'h0001;
            joy_seen_q <= hs_now ? 1'b0 : (joy_seen_q || o_joy_valid);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_tenth_set;
        hs_tick && (set_cnt_q == LAST_SET);
    endsequence

    sequence s_launch;
        o_ep3_valid && o_ep4_valid;
    endsequence

    joy_spacing_a: assert property (o_joy_valid && joy_seen_q && !hs_now
        |-> gap_q >= JOY_GAP_MIN && gap_q <= JOY_GAP_MAX)
        else $error("joystick report spacing off");
    stream_group_a: assert property (s_tenth_set |-> ##2 s_launch)
        else $error("stream report not launched after ten sets");
    temp_place_a: assert property (o_ep3_valid |-> o_ep3_report[SETS*48+15 -: 8]
        == temp_hold_q[15:8])
        else $error("temperature MSB misplaced");
    hs_refuse_a: assert property (i_rpt_valid && !i_attach && hs_now
        && cmd_code == `MS_CMD_SET_PARAMS |=> $stable(params_q))
        else $error("parameters changed in high speed mode");
    store_write_a: assert property (store_ok && !i_attach
        |=> o_nv_write && o_nv_params == $past(params_q))
        else $error("store did not write active parameters");
    attach_load_a: assert property (i_attach |=> params_q == $past(i_nv_params)
        && !o_high_speed)
        else $error("attach did not load stored parameters");
    unknown_cmd_a: assert property (i_rpt_valid && !i_attach && cmd_code != `MS_CMD_SET_PARAMS
        && cmd_code != `MS_CMD_STORE && cmd_code != `MS_CMD_HIGH_SPEED
        |=> $stable(params_q) && $stable(mode_q) && !o_nv_write)
        else $error("unknown command had an effect");
    button_map_a: assert property (o_joy_valid |-> o_joy_report[103:96]
        == ~$past(i_button_n))
        else $error("button levels not inverted");
    gyro_code_a: assert property (params_q[`MS_GYR_RANGE_LSB +: 8] != 8'h03
        && params_q[`MS_GYR_RANGE_LSB +: 8] != 8'h05 || $past(i_attach))
        else $error("reserved gyro range applied");
    hs_toggle_a: assert property (hs_ok && !i_attach |=> o_high_speed
        == $past(cmd_arg[0]))
        else $error("high speed toggle not applied");
endmodule

// ===== verif/host_model.sv
// host side model: puts eight-byte output reports on the report port
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic i_clk,
    // request from the bench
    input wire logic i_send,
    input wire logic [63:0] i_report,
    // report port toward the device
    output logic o_rpt_valid = 1'b0,
    output logic [63:0] o_rpt_data = 64'h0
);
    // ----------------------------------------
    // report sender
    // ----------------------------------------
    logic reserved;
    assign reserved = i_report[7:0] == 8'h00 && (i_report[31:24] == 8'h03
        || i_report[31:24] == 8'h05);
    // idle data is inverted each cycle so nothing stale can pass as a report
    always @(posedge i_clk) begin
        if (i_send && !reserved) begin
            o_rpt_valid <= 1'b1;
            o_rpt_data <= i_report;
        end else begin
            o_rpt_valid <= 1'b0;
            o_rpt_data <= ~o_rpt_data;
        end
    end
endmodule

// ===== verif/motion_hid_unit_tb.sv
// self-checking bench for the motion sensor report command unit
`timescale 1ns/100ps
module motion_hid_unit_tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0, arst_n = 1'b0, snd = 1'b0, att = 1'b0, rpv, rs, ws;
    logic [63:0] rpt = 64'h0, rpd;
    logic [31:0] nv = 32'h81044003, nvp, par;
    logic [15:0] ax = 16'h1234, ay = 16'h5678, az = 16'h9ABC, tmp = 16'hE700;
    logic [15:0] gx = 16'hDEF0, gy = 16'h0F1E, gz = 16'h2D3C;
    logic [7:0] btn_n = 8'h5A;
    logic rej, nvw, hs, lowlat, gon, jv, e3v, e4v;
    logic [4:0] rng_g;
    logic [2:0] chain;
    logic [18:0] pcut, st2;
    logic [10:0] gdps, ghp;
    logic [8:0] glp;
    logic [103:0] jr;
    logic [495:0] e3r, e4r;
    int bad_count = 0, num_checks = 0, i, n;
    // expected decode tables
    logic [7:0] grc [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06};
    logic [4:0] agt [4] = '{5'h02, 5'h10, 5'h04, 5'h08};
    logic [10:0] gdt [5] = '{11'h0F5, 11'h07D, 11'h1F4, 11'h3E8, 11'h7D0};
    logic [7:0] aft [5] = '{8'h20, 8'h40, 8'hC1, 8'hA2, 8'h83};
    logic [2:0] cht [5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic [18:0] cut [5] = '{19'h05159, 19'h05159, 19'h00341, 19'h02428, 19'h000D0};
    logic [10:0] ghpt [4] = '{11'h010, 11'h041, 11'h104, 11'h410};

    // short rate parameters keep report periods to tens of cycles
    motion_hid_unit #(.CLK_HZ(20000), .JOY_RATE_HZ(833), .HS_RATE_HZ(6664), .SETS(10))
    i_motion_hid_unit (.i_clk(clk), .i_arst_n(arst_n), .i_rpt_valid(rpv), .i_rpt_data(rpd),
        .i_attach(att), .i_nv_params(nv), .i_accel_x(ax), .i_accel_y(ay), .i_accel_z(az),
        .i_gyro_x(gx), .i_gyro_y(gy), .i_gyro_z(gz), .i_temp(tmp), .i_button_n(btn_n),
        .o_cmd_rejected(rej), .o_nv_write(nvw), .o_nv_params(nvp), .o_high_speed(hs),
        .o_params(par), .o_accel_range_g(rng_g), .o_accel_chain(chain),
        .o_accel_low_latency(lowlat), .o_accel_pri_cutoff(pcut), .o_accel_stage2_cutoff(st2),
        .o_gyro_range_dps(gdps), .o_gyro_lp_cutoff(glp), .o_gyro_hp_on(gon),
        .o_gyro_hp_cutoff(ghp), .o_joy_valid(jv), .o_joy_report(jr), .o_ep3_valid(e3v),
        .o_ep3_report(e3r), .o_ep4_valid(e4v), .o_ep4_report(e4r));
    host_model i_host_model (.i_clk(clk), .i_send(snd), .i_report(rpt), .o_rpt_valid(rpv),
        .o_rpt_data(rpd));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    // pulses are sampled one cycle after the host's valid, levels two later
    task send(input logic [63:0] d);
        @(posedge clk);
        #1 snd = 1'b1;
        rpt = d;
        @(posedge clk);
        #1 snd = 1'b0;
        @(posedge clk);
        #1 rs = rej;
        ws = nvw;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // counts cycles to the next stream or joystick pulse, bounded
    task wv(input logic sel, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while ((sel ? e3v : jv) !== 1'b1 && k < 400);
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------
    initial forever #25 clk = ~clk;
    // the whole run needs about two hundred cycles
    initial begin
        #(50 * 6000);
        bad_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(rng_g, 5'h02);
        chk(gdps, 11'h0F5);
        @(posedge clk);
        #1 att = 1'b1;
        @(posedge clk);
        #1 att = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(par, nv);
        chk(rng_g, 5'h08);
        for (i = 0; i < 5; i++) begin
            send({24'h0, 8'h00, grc[i], 8'h00, 6'h0, i[1:0], 8'h00});
            chk(rng_g, agt[i%4]);
            chk(gdps, gdt[i]);
            chk({rs, ws}, 2'b00);
        end
        for (i = 0; i < 5; i++) begin
            send({24'h0, (i < 4) ? 8'h80 | i[7:0] : 8'h00, 8'h00, aft[i], 16'h0});
            chk(chain, cht[i]);
            chk((i == 0) ? pcut : st2, cut[i]);
            chk(lowlat, i == 3);
            chk(gon, i < 4);
            chk(glp, 9'h0F5);
            if (i < 4) chk(ghp, ghpt[i]);
        end
        send({40'h0, 8'h60, 16'h0});
        chk({rs, par}, {1'b1, 32'h00008300});
        send(64'h07);
        chk({rs, par}, {1'b1, 32'h00008300});
        send(64'h0101);
        chk({rs, ws}, 2'b10);
        send(64'h01);
        chk({ws, nvp}, {1'b1, 32'h00008300});
        send(64'h0104);
        chk({hs, glp}, {1'b1, 9'h15F});
        chk({pcut, st2}, {19'h514C8, 19'h00681});
        send({40'h0, 8'h02, 16'h0});
        chk({rs, par}, {1'b1, 32'h00008300});
        send(64'h0204);
        chk({rs, hs}, 2'b11);
        wv(1'b1, n);
        wv(1'b1, n);
        chk(n >= 30 && n <= 31, 1'b1);
        chk(e4v, 1'b1);
        chk({e3r[47:0], e3r[479:464]}, {az, ay, ax, az});
        chk(e4r[31:16], gy);
        chk({e4r[495:480], e4r[47:32]}, {tmp, gz});
        chk(e3r[495:480], tmp);
        send(64'h0004);
        chk(hs, 1'b0);
        wv(1'b0, n);
        wv(1'b0, n);
        chk(n >= 24 && n <= 25, 1'b1);
        chk(jr[103:64], {~btn_n, gz, gy});
        chk(jr[63:0], {gx, az, ay, ax});
        final_report;
    end
endmodule
